// *** bench/adc_core_model.sv ***
// Behavioural conversion core that answers start pulses with a result.
`timescale 1ns/1ps
module adc_core_model #(parameter int LAT = 4)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Start requests from the block and from the bench.
	input wire logic conv_start,
	input wire logic trig,
	input wire logic [15:0] sample,
	// Results towards the block.
	output logic conv_done,
	output logic [15:0] conv_data,
	output logic [15:0] diff_data
);
	int cnt; // Cycles left in the running conversion.
	// Data toggles outside a done pulse, so stale use shows up.
	// converts on a start from the block or a trigger from the bench
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt <= 0;
			conv_done <= 1'b0;
			conv_data <= 16'h0000;
		end
		else
		begin
			conv_done <= (cnt == 1);
			conv_data <= (cnt == 1) ? sample : ~conv_data;
			if (cnt != 0)
				cnt <= cnt - 1;
			else if (conv_start || trig)
				cnt <= LAT;
		end
	end
	assign diff_data = conv_data ^ 16'h00ff; // Arbitrary sensing value.
endmodule

// *** bench/tb_adc_error_calculation_field_unit.sv ***
// Self-checking bench for the result computation unit.
`timescale 1ns/1ps
module tb_adc_error_calculation_field_unit;
	import adc_error_calculation_field_pkg::*;
	localparam int LAT = 4; // Core latency in cycles.
	logic mclk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, trig = 0;
	logic [11:0] adr = 0;
	logic [31:0] dat = 0, rdo, rv;
	logic [15:0] smpv = 0, cd, dd;
	logic ack, done, start, act, tif;
	int n_mismatch = 0, comparisons = 0;
	always #10 mclk = ~mclk;
	adc_error_calculation_field_unit DUT (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .conv_done(done),
		.conv_data(cd), .diff_data(dd), .conv_start(start),
		.conversion_active(act), .threshold_interrupt_flag(tif));
	adc_core_model #(.LAT(LAT)) core (.mclk(mclk), .reset_n(reset_n),
		.conv_start(start), .trig(trig), .sample(smpv), .conv_done(done),
		.conv_data(cd), .diff_data(dd));
	// Print the counts and the verdict, then end the run.
	task automatic summarize;
		$display("counts: %0d compared, %0d bad", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Compare a seen value with the expected one.
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string m);
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
		end
	endtask
	// A wait that ran out counts as a mismatch and ends the run.
	task automatic stop(input string m);
		chk(0, 1, m);
		summarize();
	endtask
	// One classic Wishbone cycle; read data is taken at the ack edge.
	task automatic bus(input logic w, input logic [9:0] i,
		input logic [15:0] d);
		int k;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {16'h0000, d};
		k = 0;
		do
		begin
			@(posedge mclk);
			k++;
		end
		while (ack !== 1'b1 && k < 20);
		rv = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
			stop("bus timeout");
	endtask
	// Read a register and compare the whole word.
	task automatic rchk(input logic [9:0] i, input logic [31:0] e,
		input string m);
		bus(1'b0, i, 16'h0000);
		chk(rv, e, m);
	endtask
	// Fire one conversion from the bench and let the pipeline settle.
	task automatic smp(input logic [15:0] v);
		@(posedge mclk);
		smpv <= v;
		trig <= 1'b1;
		@(posedge mclk);
		trig <= 1'b0;
		repeat (LAT + 5) @(posedge mclk);
	endtask
	// Wait, bounded, until the block has stopped converting.
	task automatic idle;
		int k;
		for (k = 0; k < 300 && act !== 1'b0; k++)
			@(posedge mclk);
		if (k >= 300)
			stop("still converting");
	endtask
	// Expected flag for each threshold mode, limits -5 and 5.
	function automatic logic tcond(input int m, input int e);
		case (m)
			0: return 1'b0;
			1: return e < -5;
			2: return e >= -5;
			3: return e >= -5 && e <= 5;
			4: return e < -5 || e > 5;
			5: return e <= 5;
			6: return e > 5;
			default: return 1'b1;
		endcase
	endfunction
	// Every threshold mode against errors on and around both limits.
	task automatic t_basic;
		int m, j, e;
		bus(1'b1, IDX_LOWER_THRESHOLD, 16'hfffb);
		bus(1'b1, IDX_UPPER_THRESHOLD, 16'h0005);
		for (m = 0; m < 8; m++)
			for (j = 0; j < 5; j++)
			begin
				e = -10 + 5 * j;
				bus(1'b1, IDX_COMPUTATION_STATUS, 16'h0000);
				bus(1'b1, IDX_CONTROL_THREE, {13'h0004, m[2:0]});
				smp(e[15:0]);
				rchk(IDX_ERROR_VALUE, {16'h0000, e[15:0]}, "error");
				bus(1'b0, IDX_COMPUTATION_STATUS, 16'h0000);
				chk(rv[6:5], {e > 5, e < -5}, "limits");
				chk(rv[3], tcond(m, e), "status flag");
				chk(tif, tcond(m, e), "flag out");
			end
		rchk(IDX_SUM_ACCUMULATOR, 0, "no sum");
		$display("test basic done");
	endtask
	// Accumulate with a negative sample after a clear.
	task automatic t_accum;
		bus(1'b1, IDX_CONTROL_TWO, 16'h0019);
		rchk(IDX_CONTROL_TWO, 32'h11, "clear bit");
		rchk(IDX_SAMPLE_COUNTER, 0, "count cleared");
		bus(1'b1, IDX_CONTROL_THREE, 16'h0026);
		bus(1'b1, IDX_COMPUTATION_STATUS, 16'h0000);
		smp(16'h0002);
		chk(tif, 1'b0, "below limit");
		smp(16'h0008);
		chk(tif, 1'b1, "over limit");
		smp(16'hffec);
		rchk(IDX_SUM_ACCUMULATOR, 32'hfffff6, "sum");
		rchk(IDX_FILTER_OUTPUT, 32'hfffb, "shifted");
		rchk(IDX_SAMPLE_COUNTER, 3, "count");
		$display("test accumulate done");
	endtask
	// Average of four samples, tested only at the repeat count.
	task automatic t_avg;
		int j;
		bus(1'b1, IDX_CONTROL_TWO, 16'h002a);
		bus(1'b1, IDX_REPEAT_SETTING, 16'h0004);
		bus(1'b1, IDX_CONTROL_THREE, 16'h0027);
		bus(1'b1, IDX_COMPUTATION_STATUS, 16'h0000);
		for (j = 1; j < 5; j++)
		begin
			smp(j[13:0] * 16'h0004);
			chk(tif, j == 4, "tested at repeat");
		end
		rchk(IDX_FILTER_OUTPUT, 10, "mean");
		$display("test average done");
	endtask
	// A burst of three started by software over a stale sum.
	task automatic t_burst;
		bus(1'b1, IDX_CONTROL_TWO, 16'h0003);
		bus(1'b1, IDX_REPEAT_SETTING, 16'h0003);
		bus(1'b1, IDX_SUM_ACCUMULATOR, 16'h0064);
		bus(1'b1, IDX_CONTROL_THREE, 16'h0000);
		smpv <= 16'h0007;
		bus(1'b1, IDX_CONTROL_ZERO, 16'h0081);
		idle();
		rchk(IDX_SUM_ACCUMULATOR, 21, "burst sum");
		rchk(IDX_SAMPLE_COUNTER, 3, "burst count");
		$display("test burst done");
	endtask
	// Continuous sampling until a threshold hit stops it.
	task automatic t_continuous_sampling_bit;
		bus(1'b1, IDX_CONTROL_TWO, 16'h0000);
		bus(1'b1, IDX_CONTROL_THREE, 16'h002e);
		bus(1'b1, IDX_COMPUTATION_STATUS, 16'h0000);
		smpv <= 16'h0001;
		bus(1'b1, IDX_CONTROL_ZERO, 16'h00c1);
		repeat (40) @(posedge mclk);
		chk(act, 1'b1, "still running");
		smpv <= 16'h0009;
		idle();
		chk(tif, 1'b1, "stop flag");
		bus(1'b1, IDX_CONTROL_ZERO, 16'h0080);
		$display("test continuous done");
	endtask
	// Low-pass filter with shift one, tested once two samples are in.
	task automatic t_lpf;
		bus(1'b1, IDX_CONTROL_TWO, 16'h001c);
		bus(1'b1, IDX_REPEAT_SETTING, 16'h0002);
		bus(1'b1, IDX_CONTROL_THREE, 16'h0057);
		bus(1'b1, IDX_COMPUTATION_STATUS, 16'h0000);
		smp(16'h0008);
		chk(tif, 1'b0, "lpf early");
		smp(16'h0008);
		chk(tif, 1'b1, "lpf tested");
		rchk(IDX_FILTER_OUTPUT, 6, "lpf out");
		rchk(IDX_ERROR_VALUE, 6, "filter error");
		$display("test low-pass done");
	endtask
	// Five full-scale samples overflow the sum and force the flag.
	task automatic t_ovf;
		bus(1'b1, IDX_CONTROL_TWO, 16'h0009);
		bus(1'b1, IDX_CONTROL_THREE, 16'h0010);
		bus(1'b1, IDX_COMPUTATION_STATUS, 16'h0000);
		repeat (4) smp(16'h7fff);
		chk(tif, 1'b0, "early overflow");
		smp(16'h7fff);
		bus(1'b0, IDX_COMPUTATION_STATUS, 16'h0000);
		chk(rv[7], 1'b1, "overflow");
		chk(tif, 1'b1, "overflow flag");
		rchk(IDX_ERROR_VALUE, 32'h7f00, "sensing error");
		bus(1'b1, IDX_CONTROL_TWO, 16'h0008);
		rchk(IDX_SUM_ACCUMULATOR, 0, "cleared");
		$display("test overflow done");
	endtask
	// Double sampling: the pair is tested only after its second half.
	task automatic t_pair;
		bus(1'b1, IDX_CONTROL_ONE, 16'h0001);
		bus(1'b1, IDX_CONTROL_THREE, 16'h0007);
		bus(1'b1, IDX_COMPUTATION_STATUS, 16'h0000);
		smp(16'h0064);
		bus(1'b0, IDX_COMPUTATION_STATUS, 16'h0000);
		chk(rv[4:3], 2'b10, "first of pair");
		smp(16'h0082);
		rchk(IDX_PREVIOUS_RESULT, 32'h64, "previous");
		rchk(IDX_CONVERSION_RESULT, 32'h82, "result");
		rchk(IDX_ERROR_VALUE, 32'h1e, "pair error");
		chk(tif, 1'b1, "pair flag");
		$display("test pair done");
	endtask
	// Main sequence: reset, bus checks, then each scenario.
	initial
	begin
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		rchk(IDX_LOWER_THRESHOLD, 0, "reset value");
		bus(1'b1, 10'h0a0, 16'h1234);
		rchk(10'h0a0, 0, "unmapped");
		bus(1'b1, IDX_CONTROL_ZERO, 16'h0080);
		t_basic();
		t_accum();
		t_avg();
		t_burst();
		t_continuous_sampling_bit();
		t_lpf();
		t_ovf();
		t_pair();
		summarize();
	end
endmodule

// *** rtl/adc_error_calculation_field_pkg.sv ***
// Constants shared by the conversion result computation unit.
package adc_error_calculation_field_pkg;
	// ********************************************************
	// Register indices; the Wishbone byte address is four times each.
	// ********************************************************
	localparam logic [9:0] IDX_LOWER_THRESHOLD = 10'h08c;
	localparam logic [9:0] IDX_UPPER_THRESHOLD = 10'h08e;
	localparam logic [9:0] IDX_ERROR_VALUE = 10'h090;
	localparam logic [9:0] IDX_SETPOINT_VALUE = 10'h092;
	localparam logic [9:0] IDX_FILTER_OUTPUT = 10'h094;
	localparam logic [9:0] IDX_SUM_ACCUMULATOR = 10'h096;
	localparam logic [9:0] IDX_SAMPLE_COUNTER = 10'h099;
	localparam logic [9:0] IDX_REPEAT_SETTING = 10'h09a;
	localparam logic [9:0] IDX_PREVIOUS_RESULT = 10'h09b;
	localparam logic [9:0] IDX_CONVERSION_RESULT = 10'h09d;
	localparam logic [9:0] IDX_CONTROL_ZERO = 10'h111;
	localparam logic [9:0] IDX_CONTROL_ONE = 10'h112;
	localparam logic [9:0] IDX_CONTROL_TWO = 10'h113;
	localparam logic [9:0] IDX_CONTROL_THREE = 10'h114;
	localparam logic [9:0] IDX_COMPUTATION_STATUS = 10'h115;
	// Plain storage registers: channel, acquisition, capacitance,
	// precharge, reference, auto trigger, clock select, charge pump.
	localparam int MISC_NUM = 8;
	localparam logic [9:0] MISC_IDX [MISC_NUM] = '{10'h09f, 10'h10c,
		10'h10e, 10'h10f, 10'h116, 10'h117, 10'h118, 10'h29e};
	localparam logic [15:0] MISC_MASK [MISC_NUM] = '{16'h00ff, 16'hffff,
		16'h00ff, 16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
	// ********************************************************
	// Field positions.
	// ********************************************************
	localparam int ON_BIT = 7;
	localparam int CONTINUOUS_SAMPLING_BIT_BIT = 6;
	localparam int GO_BIT = 0;
	localparam int DOUBLE_SAMPLE_ENABLE_BIT = 0;
	localparam int PREVIOUS_SOURCE_BIT_BIT = 7;
	localparam int SHIFT_LSB = 4;
	localparam int ACCUMULATOR_CLEAR_BIT_BIT = 3;
	localparam int ERROR_CALCULATION_FIELD_LSB = 4;
	localparam int SOI_BIT = 3;
	localparam int OV_BIT = 7;
	localparam int ABOVE_UPPER_FLAG_BIT = 6;
	localparam int BELOW_LOWER_FLAG_BIT = 5;
	localparam int FIRST_OF_PAIR_FLAG_BIT = 4;
	localparam int TIF_BIT = 3;
	// ********************************************************
	// Computation mode codes.
	// ********************************************************
	localparam logic [2:0] MD_BASIC = 3'h0;
	localparam logic [2:0] MD_ACCUM = 3'h1;
	localparam logic [2:0] MD_AVERAGE = 3'h2;
	localparam logic [2:0] MD_BURST = 3'h3;
	localparam logic [2:0] MD_LOWPASS = 3'h4;
	localparam logic [7:0] CNT_MAX = 8'hff;
endpackage

// *** rtl/adc_error_calculation_field_unit.sv ***
// Result computation unit: accumulate, filter, error and threshold test.
// Overview of operation
// - mode 001 adds every result to accumulator.
// - filter output is accumulator shifted right.
// - filter output always right-justified.
// - sample counter increments per accumulated sample.
// - accumulate mode tests threshold every sample.
// - mode 010 tests only when count reaches repeat.
// - average mode shift yields sample mean.
// - mode 011 retriggers until count reaches repeat.
// - mode 100 low-pass filters, tests after repeat.
// - results latched before error and test.
// - error chosen by error calculation field.
// - compare error, update above/below flags.
// - threshold mode selects interrupt condition.
// - met condition sets threshold interrupt flag.
// - threshold comparisons are signed.
// - accumulator overflow also signals threshold interrupt.
// - continuous bit retriggers, keeps conversion active.
// - stop-on-interrupt clears active bit, stops.
// - first of pair: flag, accumulate, no test.
// - second of pair moves previous, result, tests.
// - overflow flag set when sum overflows.
// - clear bit clears accumulator, overflow, counter.
// - burst mode clears accumulator at trigger.
// - mode 000 no accumulation, still tests.
`timescale 1ns/1ps
module adc_error_calculation_field_unit
	import adc_error_calculation_field_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Conversion core.
	input wire logic conv_done,
	input wire logic [15:0] conv_data,
	input wire logic [15:0] diff_data,
	output logic conv_start,
	// Status levels.
	output logic conversion_active,
	output logic threshold_interrupt_flag
);
	// ********************************************************
	// Bus decode.
	// ********************************************************
	logic ack_ff; // Acknowledge, one cycle per request.
	logic [31:0] rdat_ff; // Registered read data.
	logic [9:0] idx; // Word index of the request.
	logic wr; // Write taken this cycle.
	logic [31:0] bmask; // Byte-lane write mask.
	assign idx = wb_adr_i[11:2];
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// Merge write data into the old value by byte lane.
	function automatic logic [31:0] merge(input logic [31:0] old);
		merge = (old & ~bmask) | (wb_dat_i & bmask);
	endfunction

	// ********************************************************
	// Register state.
	// ********************************************************
	logic signed [15:0] lth_ff; // Lower threshold.
	logic signed [15:0] uth_ff; // Upper threshold.
	logic signed [15:0] stpt_ff; // Setpoint.
	logic signed [15:0] err_ff; // Error value.
	logic signed [15:0] flt_ff; // Filter output.
	logic signed [15:0] flt_old_ff; // Filter output before last update.
	logic signed [17:0] acc_ff; // Sum accumulator.
	logic [7:0] cnt_ff; // Sample counter.
	logic [7:0] rpt_ff; // Repeat setting.
	logic signed [15:0] prev_ff; // Previous result.
	logic signed [15:0] res_ff; // Conversion result.
	logic [15:0] diff_ff; // Sensing result, held so stage two sees it.
	logic [7:0] con0_ff; // Control zero, GO kept apart.
	logic [7:0] con1_ff; // Control one.
	logic [7:0] con2_ff; // Control two, clear bit kept apart.
	logic [7:0] con3_ff; // Control three.
	logic [15:0] misc_ff [MISC_NUM]; // Plain storage registers.
	logic go_ff; // Conversion in progress.
	logic accumulator_clear_bit_ff; // Accumulator clear pending.
	logic ov_ff; // Accumulator overflow flag.
	logic above_upper_flag_ff; // Error above upper threshold.
	logic below_lower_flag_ff; // Error below lower threshold.
	logic first_of_pair_flag_ff; // First of a pair captured.
	logic tif_ff; // Threshold interrupt flag.
	logic start_ff; // Start pulse to the core.
	logic done_ff; // Stage two of a completed conversion.
	logic error_calculation_field_ff; // Stage two computes error this time.
	logic test_ff; // Stage two performs the threshold test.
	logic keep_ff; // Stage two retriggers the core.

	// Mode field views.
	logic [2:0] md;
	logic [2:0] shift_count;
	logic [2:0] error_calculation_field;
	logic [2:0] threshold_mode_field;
	assign md = con2_ff[2:0];
	assign shift_count = con2_ff[SHIFT_LSB +: 3];
	assign error_calculation_field = con3_ff[ERROR_CALCULATION_FIELD_LSB +: 3];
	assign threshold_mode_field = con3_ff[2:0];

	// Software setting GO while the unit is on.
	logic go_set;
	assign go_set = wr && idx == IDX_CONTROL_ZERO && wb_sel_i[0]
		&& wb_dat_i[GO_BIT] && !go_ff && con0_ff[ON_BIT];

	// ********************************************************
	// Bus acknowledge and read data.
	// ********************************************************
	// One wait state: ack rises the edge after the request and
	// falls the edge after, so back-to-back requests never merge.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			ack_ff <= 1'b0;
		else
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
	end

	// Read mux; unmapped indices answer zero.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rdat_ff <= 32'h0000_0000;
		else if (!(wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff))
			rdat_ff <= rdat_ff;
		else if (idx == IDX_LOWER_THRESHOLD)
			rdat_ff <= {16'h0000, lth_ff};
		else if (idx == IDX_UPPER_THRESHOLD)
			rdat_ff <= {16'h0000, uth_ff};
		else if (idx == IDX_ERROR_VALUE)
			rdat_ff <= {16'h0000, err_ff};
		else if (idx == IDX_SETPOINT_VALUE)
			rdat_ff <= {16'h0000, stpt_ff};
		else if (idx == IDX_FILTER_OUTPUT)
			rdat_ff <= {16'h0000, flt_ff};
		else if (idx == IDX_SUM_ACCUMULATOR)
			rdat_ff <= {8'h00, {6{acc_ff[17]}}, acc_ff};
		else if (idx == IDX_SAMPLE_COUNTER)
			rdat_ff <= {24'h000000, cnt_ff};
		else if (idx == IDX_REPEAT_SETTING)
			rdat_ff <= {24'h000000, rpt_ff};
		else if (idx == IDX_PREVIOUS_RESULT)
			rdat_ff <= {16'h0000, prev_ff};
		else if (idx == IDX_CONVERSION_RESULT)
			rdat_ff <= {16'h0000, res_ff};
		else if (idx == IDX_CONTROL_ZERO)
			rdat_ff <= {24'h000000, con0_ff[7:1], go_ff};
		else if (idx == IDX_CONTROL_ONE)
			rdat_ff <= {24'h000000, con1_ff};
		else if (idx == IDX_CONTROL_TWO)
			rdat_ff <= {24'h000000, con2_ff[7:4], accumulator_clear_bit_ff, con2_ff[2:0]};
		else if (idx == IDX_CONTROL_THREE)
			rdat_ff <= {24'h000000, con3_ff};
		else if (idx == IDX_COMPUTATION_STATUS)
			rdat_ff <= {24'h000000, ov_ff, above_upper_flag_ff, below_lower_flag_ff, first_of_pair_flag_ff,
				tif_ff, 2'b00, go_ff};
		else
		begin
			rdat_ff <= 32'h0000_0000;
			for (int i = 0; i < MISC_NUM; i++)
				if (idx == MISC_IDX[i])
					rdat_ff <= {16'h0000, misc_ff[i] & MISC_MASK[i]};
		end
	end

	// ********************************************************
	// Software-only registers.
	// ********************************************************
	// Thresholds, setpoint, repeat setting and control bytes.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lth_ff <= 16'sh0000;
			uth_ff <= 16'sh0000;
			stpt_ff <= 16'sh0000;
			rpt_ff <= 8'h00;
			con0_ff <= 8'h00;
			con1_ff <= 8'h00;
			con2_ff <= 8'h00;
			con3_ff <= 8'h00;
		end
		else if (wr)
		begin
			if (idx == IDX_LOWER_THRESHOLD)
				lth_ff <= 16'(merge({16'h0000, lth_ff}));
			else if (idx == IDX_UPPER_THRESHOLD)
				uth_ff <= 16'(merge({16'h0000, uth_ff}));
			else if (idx == IDX_SETPOINT_VALUE)
				stpt_ff <= 16'(merge({16'h0000, stpt_ff}));
			else if (idx == IDX_REPEAT_SETTING)
				rpt_ff <= 8'(merge({24'h000000, rpt_ff}));
			else if (idx == IDX_CONTROL_ZERO)
				con0_ff <= 8'(merge({24'h000000, con0_ff}));
			else if (idx == IDX_CONTROL_ONE)
				con1_ff <= 8'(merge({24'h000000, con1_ff}));
			else if (idx == IDX_CONTROL_TWO)
				con2_ff <= 8'(merge({24'h000000, con2_ff}));
			else if (idx == IDX_CONTROL_THREE)
				con3_ff <= 8'(merge({24'h000000, con3_ff}));
		end
	end

	// Storage the unit keeps for the analog side but never reads.
	for (genvar g = 0; g < MISC_NUM; g++)
	begin : g_misc
		always_ff @(posedge mclk or negedge reset_n)
		begin
			if (!reset_n)
				misc_ff[g] <= 16'h0000;
			else if (wr && idx == MISC_IDX[g])
				misc_ff[g] <= 16'(merge({16'h0000, misc_ff[g]}));
		end
	end

	// ********************************************************
	// Stage one: accumulate on conversion complete.
	// ********************************************************
	logic dbl_first; // This conversion is the first of a pair.
	logic restart; // Average mode starts a fresh batch.
	logic signed [17:0] base; // Accumulator before the add.
	logic signed [18:0] sum; // Wide sum for overflow detection.
	logic signed [17:0] acc_new;
	logic [7:0] cnt_base;
	logic [7:0] cnt_new;
	logic accum; // Mode accumulates at all.
	assign dbl_first = con1_ff[DOUBLE_SAMPLE_ENABLE_BIT] && !first_of_pair_flag_ff;
	assign restart = md == MD_AVERAGE && cnt_ff >= rpt_ff;
	assign accum = md != MD_BASIC && md <= MD_LOWPASS;
	assign base = restart ? 18'sh00000 : acc_ff;
	assign cnt_base = restart ? 8'h00 : cnt_ff;

	// The low-pass form leaks the shifted accumulator back out.
	always_comb
	begin
		if (md == MD_LOWPASS)
			sum = 19'(base) + 19'(signed'(conv_data)) - 19'(base >>> shift_count);
		else
			sum = 19'(base) + 19'(signed'(conv_data));
	end
	assign acc_new = sum[17:0];
	assign cnt_new = cnt_base == CNT_MAX ? cnt_base : cnt_base + 8'h01;

	// Accumulator, counter and overflow; the clear bit wins over a
	// sample arriving in the same cycle since software asked last.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_ff <= 18'sh00000;
			cnt_ff <= 8'h00;
			ov_ff <= 1'b0;
		end
		else if (accumulator_clear_bit_ff)
		begin
			acc_ff <= 18'sh00000;
			cnt_ff <= 8'h00;
			ov_ff <= 1'b0;
		end
		else if (go_set && md == MD_BURST)
		begin
			acc_ff <= 18'sh00000;
			cnt_ff <= 8'h00;
		end
		else if (conv_done && accum)
		begin
			acc_ff <= acc_new;
			cnt_ff <= cnt_new;
			if (sum[18] != sum[17])
				ov_ff <= 1'b1;
			else if (restart)
				ov_ff <= 1'b0;
		end
		else if (wr && !go_ff && idx == IDX_SUM_ACCUMULATOR)
			acc_ff <= 18'(merge({8'h00, {6{acc_ff[17]}}, acc_ff}));
		else if (wr && idx == IDX_SAMPLE_COUNTER)
			cnt_ff <= 8'(merge({24'h000000, cnt_ff}));
	end

	// Clear request: set by software, dropped by hardware once done.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			accumulator_clear_bit_ff <= 1'b0;
		else if (accumulator_clear_bit_ff)
			accumulator_clear_bit_ff <= 1'b0;
		else if (wr && idx == IDX_CONTROL_TWO && wb_sel_i[0])
			accumulator_clear_bit_ff <= wb_dat_i[ACCUMULATOR_CLEAR_BIT_BIT];
	end

	// Filter output, result and previous value.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			flt_ff <= 16'sh0000;
			flt_old_ff <= 16'sh0000;
			res_ff <= 16'sh0000;
			prev_ff <= 16'sh0000;
			diff_ff <= 16'h0000;
		end
		else if (conv_done)
		begin
			// The core moves on after its pulse, so keep its sensing value.
			diff_ff <= diff_data;
			if (accum)
			begin
				flt_old_ff <= flt_ff;
				flt_ff <= 16'(acc_new >>> shift_count);
			end
			if (!dbl_first)
			begin
				res_ff <= conv_data;
				if (con1_ff[DOUBLE_SAMPLE_ENABLE_BIT])
					prev_ff <= con2_ff[PREVIOUS_SOURCE_BIT_BIT] ? flt_ff : res_ff;
				else
					prev_ff <= con2_ff[PREVIOUS_SOURCE_BIT_BIT] ? flt_ff : res_ff;
			end
			else
				res_ff <= conv_data;
		end
	end

	// First-of-pair flag toggles through a double sample.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			first_of_pair_flag_ff <= 1'b0;
		else if (conv_done && con1_ff[DOUBLE_SAMPLE_ENABLE_BIT])
			first_of_pair_flag_ff <= !first_of_pair_flag_ff;
		else if (!con1_ff[DOUBLE_SAMPLE_ENABLE_BIT])
			first_of_pair_flag_ff <= 1'b0;
	end

	// Stage-two controls decided from the new count.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			done_ff <= 1'b0;
			error_calculation_field_ff <= 1'b0;
			test_ff <= 1'b0;
			keep_ff <= 1'b0;
		end
		else
		begin
			done_ff <= conv_done;
			// no error on the first of a pair
			error_calculation_field_ff <= conv_done && !dbl_first;
			test_ff <= !(md == MD_AVERAGE || md == MD_BURST ||
				md == MD_LOWPASS) || cnt_new >= rpt_ff;
			keep_ff <= con0_ff[CONTINUOUS_SAMPLING_BIT_BIT] ||
				(md == MD_BURST && cnt_new < rpt_ff);
		end
	end

	// ********************************************************
	// Stage two: error and threshold test on latched values.
	// ********************************************************
	logic signed [15:0] err_new;
	logic above;
	logic below;
	logic cond;
	logic hit; // Threshold interrupt condition this cycle.
	always_comb
	begin
		case (error_calculation_field)
			3'h0: err_new = res_ff - prev_ff;
			3'h1: err_new = diff_ff;
			3'h2: err_new = res_ff - stpt_ff;
			3'h3: err_new = res_ff - flt_ff;
			3'h4: err_new = flt_ff - flt_old_ff;
			3'h5: err_new = flt_ff - stpt_ff;
			default: err_new = 16'sh0000;
		endcase
	end
	assign above = err_new > uth_ff;
	assign below = err_new < lth_ff;
	always_comb
	begin
		case (threshold_mode_field)
			3'h0: cond = 1'b0;
			3'h1: cond = below;
			3'h2: cond = !below;
			3'h3: cond = !below && !above;
			3'h4: cond = below || above;
			3'h5: cond = !above;
			3'h6: cond = above;
			default: cond = 1'b1;
		endcase
	end
	assign hit = error_calculation_field_ff && test_ff && (cond || ov_ff);

	// Error register and comparison flags.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			err_ff <= 16'sh0000;
			above_upper_flag_ff <= 1'b0;
			below_lower_flag_ff <= 1'b0;
		end
		else if (error_calculation_field_ff && test_ff)
		begin
			err_ff <= err_new;
			above_upper_flag_ff <= above;
			below_lower_flag_ff <= below;
		end
	end

	// Interrupt flag: a new hit wins over a software clear.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			tif_ff <= 1'b0;
		else if (hit)
			tif_ff <= 1'b1;
		else if (wr && idx == IDX_COMPUTATION_STATUS && wb_sel_i[0]
			&& !wb_dat_i[TIF_BIT])
			tif_ff <= 1'b0;
	end
	assign threshold_interrupt_flag = tif_ff;

	// ********************************************************
	// Conversion sequencing.
	// ********************************************************
	// GO stays high across retriggers and falls at the end of the
	// last one, or at once when a hit stops the run.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			go_ff <= 1'b0;
		else if (hit && con3_ff[SOI_BIT])
			go_ff <= 1'b0;
		else if (go_set)
			go_ff <= 1'b1;
		else if (wr && idx == IDX_CONTROL_ZERO && wb_sel_i[0]
			&& !wb_dat_i[GO_BIT])
			go_ff <= 1'b0;
		else if (done_ff && !keep_ff)
			go_ff <= 1'b0;
	end
	assign conversion_active = go_ff;

	// Start pulse: once on a software GO, then per retrigger.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			start_ff <= 1'b0;
		else
			start_ff <= go_set || (done_ff && keep_ff && go_ff &&
				!(hit && con3_ff[SOI_BIT]));
	end
	assign conv_start = start_ff;

	// ********************************************************
	// Assertions.
	// ********************************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !ack_ff;
	endsequence
	a_bus_ack_pulse: assert property (s_req |=> ack_ff ##1 !ack_ff)
		else $error("ack not a single pulse");
	a_accum_add: assert property (conv_done && md == MD_ACCUM && !accumulator_clear_bit_ff
		&& !go_set && sum[18] == sum[17]
		|=> acc_ff == $past(acc_ff) + 18'(signed'($past(conv_data))))
		else $error("accumulator did not add sample");
	a_count_step: assert property (conv_done && accum && !accumulator_clear_bit_ff
		&& !go_set && !restart && cnt_ff != CNT_MAX
		|=> cnt_ff == $past(cnt_ff) + 8'h01)
		else $error("sample counter did not step");
	a_filter_shift: assert property ($rose(done_ff) && md == MD_ACCUM
		|-> flt_ff == 16'(acc_ff >>> shift_count))
		else $error("filter output not shifted accumulator");
	a_clear_all: assert property (accumulator_clear_bit_ff
		|=> acc_ff == 18'sh0 && cnt_ff == 8'h0 && !ov_ff && !accumulator_clear_bit_ff)
		else $error("accumulator clear incomplete");
	a_tif_set: assert property (hit |=> tif_ff)
		else $error("threshold flag not set");
	a_first_no_err: assert property (conv_done && dbl_first
		|=> !error_calculation_field_ff ##1 $stable(err_ff))
		else $error("error computed on first of pair");
	a_soi_stop: assert property (hit && con3_ff[SOI_BIT]
		|=> !go_ff && !start_ff)
		else $error("stop on interrupt failed");
	a_burst_retrig: assert property (done_ff && keep_ff && go_ff
		&& !hit |=> start_ff && go_ff)
		else $error("burst or continuous did not retrigger");
	a_signed_cmp: assert property (error_calculation_field_ff && test_ff
		|=> above_upper_flag_ff == ($signed(err_ff) > $signed(uth_ff)))
		else $error("upper comparison wrong");
endmodule
